/* File: dcd_params.svh */
// Register offsets, field positions, frame lengths and reset values of the command decoder.
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH
`define DCD_ADDR_RELOAD 8'h01
`define DCD_ADDR_LAMP 8'h02
`define DCD_ADDR_IN_TUNE 8'h10
`define DCD_ADDR_OUT_TUNE 8'h11
`define DCD_ADDR_PREAMP 8'h12
`define DCD_ADDR_STEP 8'h13
`define DCD_ADDR_ROUTE 8'h14
`define DCD_ADDR_AUTO 8'h15
`define DCD_ADDR_SAVE 8'h16
`define DCD_ADDR_STANDBY 8'h17
`define DCD_ADDR_TIMEBASE 8'h18
`define DCD_ADDR_TRIM 8'h19
`define DCD_ADDR_PLAN 8'h1a
`define DCD_ADDR_LOOP 8'h1b
`define DCD_ADDR_CAL 8'h1c
`define DCD_ADDR_NVM 8'h1d
`define DCD_LEN_1 4'h1
`define DCD_LEN_3 4'h3
`define DCD_LEN_5 4'h5
`define DCD_LEN_7 4'h7
`define DCD_BIT_DIRECT 48
`define DCD_STEP_VAL_MSB 7
`define DCD_STEP_SEL_LSB 8
`define DCD_STEP_SEL_MSB 10
`define DCD_STEP_IN1 3'h0
`define DCD_STEP_IN2 3'h1
`define DCD_STEP_OUT1 3'h3
`define DCD_STEP_OUT2 3'h4
`define DCD_RST_STEP 8'h00
`define DCD_RST_TUNE 48'h0
`define DCD_ACK_BYTE 8'h00
`endif

/* File: dcd_pkg.sv */
// Types shared by the command decoder files.
package dcd_pkg;
  typedef enum logic [2:0] {
    DCD_IDLE = 3'b001,
    DCD_DATA = 3'b010,
    DCD_EXEC = 3'b100
  } dcd_state_e;

  typedef struct packed {
    logic front_amplifier_on;
    logic second_stage_filter_pick;
    logic spectral_flip;
    logic direct_pass_through;
  } dcd_route_s;

  typedef struct packed {
    logic auto_enable;
    logic tracking_drives_amplifier;
    logic [1:0] noise_vs_linearity_choice;
    logic [7:0] expected_input_level;
    logic [7:0] expected_first_stage_level;
    logic [7:0] expected_output_level;
  } dcd_auto_s;

  typedef struct packed {
    logic [7:0] in1;
    logic [7:0] in2;
    logic [7:0] out1;
    logic [7:0] out2;
  } dcd_steps_s;
endpackage

/* File: dcd_len_lookup.sv */
// Maps a register address byte to the number of data bytes that follow it.
`timescale 1ns/100ps
`include "dcd_params.svh"
module dcd_len_lookup (
  input wire logic [7:0] addr_i,
  output logic [3:0] len_o,
  output logic known_o
);
  always_comb begin
    len_o = `DCD_LEN_1;
    known_o = 1'b1;
    if (addr_i == `DCD_ADDR_IN_TUNE || addr_i == `DCD_ADDR_OUT_TUNE ||
        addr_i == `DCD_ADDR_PLAN) begin
      len_o = `DCD_LEN_7;
    end else if (addr_i == `DCD_ADDR_STEP || addr_i == `DCD_ADDR_TRIM ||
                 addr_i == `DCD_ADDR_NVM) begin
      len_o = `DCD_LEN_3;
    end else if (addr_i == `DCD_ADDR_AUTO) begin
      len_o = `DCD_LEN_5;
    end else if (addr_i == `DCD_ADDR_RELOAD || addr_i == `DCD_ADDR_LAMP ||
                 addr_i == `DCD_ADDR_PREAMP || addr_i == `DCD_ADDR_ROUTE ||
                 (addr_i >= `DCD_ADDR_SAVE && addr_i <= `DCD_ADDR_CAL)) begin
      len_o = `DCD_LEN_1;
    end else begin
      known_o = 1'b0;
    end
  end
endmodule

/* File: dcd_decoder.sv */
// Byte-serial command decoder for the downconverter configuration registers.
`timescale 1ns/100ps
`include "dcd_params.svh"
module dcd_decoder
  import dcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  input wire logic ack_enable_i,
  output logic ack_valid_o,
  output logic [7:0] ack_byte_o,
  input wire logic ack_ready_i,
  output logic activity_lamp_o,
  output logic [47:0] input_tuning_word_o,
  output logic input_tune_pulse_o,
  output logic [47:0] first_oscillator_direct_o,
  output logic first_oscillator_direct_pulse_o,
  output logic [47:0] output_tuning_word_o,
  output logic output_tune_pulse_o,
  output logic preamp_on_o,
  output dcd_steps_s steps_o,
  output dcd_route_s route_o,
  output dcd_auto_s auto_o,
  output logic reprogram_pulse_o,
  output logic restore_default_pulse_o,
  output logic [7:0] other_addr_o,
  output logic [23:0] other_data_o,
  output logic other_pulse_o
);
  dcd_state_e state_r;
  logic [7:0] addr_r;
  logic [55:0] data_r;
  logic [3:0] cnt_r;
  logic [3:0] len_w;
  logic known_w;
  logic take_w;
  logic exec_w;
  logic [3:0] len_r;
  logic manual_amp_r;
  logic ack_pend_r;
  logic [55:0] data_nxt;

  dcd_len_lookup u_len (
    .addr_i(rx_byte_i),
    .len_o(len_w),
    .known_o(known_w)
  );

  // Bytes are held off while an acknowledge is still owed to the host.
  assign rx_ready_o = (state_r != DCD_EXEC) && !ack_pend_r;
  assign take_w = rx_valid_i && rx_ready_o;
  assign exec_w = (state_r == DCD_EXEC);

  // Data bytes land least significant first.
  always_comb begin
    data_nxt = data_r;
    data_nxt[cnt_r*8 +: 8] = rx_byte_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= DCD_IDLE;
      addr_r <= 8'h00;
      cnt_r <= 4'h0;
      len_r <= 4'h0;
      data_r <= 56'h0;
    end else begin
      case (state_r)
        DCD_IDLE: begin
          if (take_w && known_w) begin
            addr_r <= rx_byte_i;
            len_r <= len_w;
            cnt_r <= 4'h0;
            data_r <= 56'h0;
            state_r <= DCD_DATA;
          end
        end
        DCD_DATA: begin
          if (take_w) begin
            data_r <= data_nxt;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r + 4'h1 == len_r) begin
              state_r <= DCD_EXEC;
            end
          end
        end
        DCD_EXEC: begin
          state_r <= DCD_IDLE;
        end
        default: begin
          state_r <= DCD_IDLE;
        end
      endcase
    end
  end

  function automatic logic [3:0] len_of(input logic [7:0] a);
    logic [3:0] l;
    l = `DCD_LEN_1;
    if (a == `DCD_ADDR_IN_TUNE || a == `DCD_ADDR_OUT_TUNE || a == `DCD_ADDR_PLAN) begin
      l = `DCD_LEN_7;
    end else if (a == `DCD_ADDR_STEP || a == `DCD_ADDR_TRIM || a == `DCD_ADDR_NVM) begin
      l = `DCD_LEN_3;
    end else if (a == `DCD_ADDR_AUTO) begin
      l = `DCD_LEN_5;
    end
    return l;
  endfunction

  // Acknowledge after every completed write, on links that use it.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_pend_r <= 1'b0;
    end else if (exec_w && ack_enable_i) begin
      ack_pend_r <= 1'b1;
    end else if (ack_ready_i) begin
      ack_pend_r <= 1'b0;
    end
  end
  assign ack_valid_o = ack_pend_r;
  assign ack_byte_o = `DCD_ACK_BYTE;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reprogram_pulse_o <= 1'b0;
      restore_default_pulse_o <= 1'b0;
    end else begin
      reprogram_pulse_o <= exec_w && addr_r == `DCD_ADDR_RELOAD && !data_r[0];
      restore_default_pulse_o <= exec_w && addr_r == `DCD_ADDR_RELOAD && data_r[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || restore_default_pulse_o) begin
      activity_lamp_o <= 1'b0;
    end else if (exec_w && addr_r == `DCD_ADDR_LAMP) begin
      activity_lamp_o <= data_r[0];
    end
  end

  // Tuning words take effect straight from reset, no reload needed.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || restore_default_pulse_o) begin
      input_tuning_word_o <= `DCD_RST_TUNE;
      first_oscillator_direct_o <= `DCD_RST_TUNE;
      output_tuning_word_o <= `DCD_RST_TUNE;
      input_tune_pulse_o <= 1'b0;
      first_oscillator_direct_pulse_o <= 1'b0;
      output_tune_pulse_o <= 1'b0;
    end else begin
      input_tune_pulse_o <= 1'b0;
      first_oscillator_direct_pulse_o <= 1'b0;
      output_tune_pulse_o <= 1'b0;
      if (exec_w && addr_r == `DCD_ADDR_IN_TUNE) begin
        if (data_r[`DCD_BIT_DIRECT]) begin
          first_oscillator_direct_o <= data_r[47:0];
          first_oscillator_direct_pulse_o <= 1'b1;
        end else begin
          input_tuning_word_o <= data_r[47:0];
          input_tune_pulse_o <= 1'b1;
        end
      end
      if (exec_w && addr_r == `DCD_ADDR_OUT_TUNE) begin
        output_tuning_word_o <= data_r[47:0];
        output_tune_pulse_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || restore_default_pulse_o) begin
      steps_o <= '0;
    end else if (exec_w && addr_r == `DCD_ADDR_STEP) begin
      case (data_r[`DCD_STEP_SEL_MSB:`DCD_STEP_SEL_LSB])
        `DCD_STEP_IN1: steps_o.in1 <= data_r[`DCD_STEP_VAL_MSB:0];
        `DCD_STEP_IN2: steps_o.in2 <= data_r[`DCD_STEP_VAL_MSB:0];
        `DCD_STEP_OUT1: steps_o.out1 <= data_r[`DCD_STEP_VAL_MSB:0];
        `DCD_STEP_OUT2: steps_o.out2 <= data_r[`DCD_STEP_VAL_MSB:0];
        default: steps_o <= steps_o;
      endcase
    end
  end

  // Amplifier: last PREAMP or ROUTE write wins; ROUTE writes leave it alone while tracking owns it.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || restore_default_pulse_o) begin
      manual_amp_r <= 1'b0;
      route_o <= '0;
    end else if (exec_w && addr_r == `DCD_ADDR_PREAMP) begin
      manual_amp_r <= data_r[0];
    end else if (exec_w && addr_r == `DCD_ADDR_ROUTE) begin
      if (!(auto_o.auto_enable && auto_o.tracking_drives_amplifier)) begin
        manual_amp_r <= data_r[0];
      end
      route_o <= {data_r[0], data_r[1], data_r[2], data_r[3]};
    end
  end
  assign preamp_on_o = manual_amp_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || restore_default_pulse_o) begin
      auto_o <= '0;
    end else if (exec_w && addr_r == `DCD_ADDR_AUTO) begin
      auto_o.auto_enable <= data_r[0];
      if (data_r[1]) begin
        auto_o.tracking_drives_amplifier <= data_r[2];
        auto_o.noise_vs_linearity_choice <= data_r[4:3];
        auto_o.expected_input_level <= data_r[15:8];
        auto_o.expected_first_stage_level <= data_r[23:16];
        auto_o.expected_output_level <= data_r[31:24];
      end
    end
  end

  // Registers 0x16 to 0x1d are passed on raw.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      other_addr_o <= 8'h00;
      other_data_o <= 24'h0;
      other_pulse_o <= 1'b0;
    end else begin
      other_pulse_o <= exec_w && addr_r >= `DCD_ADDR_SAVE;
      if (exec_w && addr_r >= `DCD_ADDR_SAVE) begin
        other_addr_o <= addr_r;
        other_data_o <= data_r[23:0];
      end
    end
  end

  property p_ack_after_exec;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && ack_enable_i) |=> ack_valid_o;
  endproperty
  a_ack_after_exec: assert property (p_ack_after_exec) else $error("no acknowledge");

  property p_lamp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_LAMP) |=> activity_lamp_o == $past(data_r[0]);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp mismatch");

  property p_direct;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_IN_TUNE && data_r[48]) |=> $stable(input_tuning_word_o);
  endproperty
  a_direct: assert property (p_direct) else $error("input word changed");

  property p_in_tune;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_IN_TUNE && !data_r[48]) |=> input_tune_pulse_o;
  endproperty
  a_in_tune: assert property (p_in_tune) else $error("input tune missed");

  property p_out_tune;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_OUT_TUNE) |=> output_tuning_word_o == $past(data_r[47:0]);
  endproperty
  a_out_tune: assert property (p_out_tune) else $error("output tune mismatch");

  property p_no_take_exec;
    @(posedge sys_clk_i) disable iff (rst_i)
      exec_w |-> !rx_ready_o;
  endproperty
  a_no_take_exec: assert property (p_no_take_exec) else $error("byte taken in exec");

  property p_frame_len;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_r == DCD_DATA) |-> cnt_r < len_of(addr_r);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame overrun");

  property p_auto_gate;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_AUTO && !data_r[1]) |=> $stable(auto_o.expected_input_level);
  endproperty
  a_auto_gate: assert property (p_auto_gate) else $error("levels loaded ungated");

  property p_route_amp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_ROUTE && auto_o.auto_enable &&
       auto_o.tracking_drives_amplifier) |=> $stable(manual_amp_r);
  endproperty
  a_route_amp: assert property (p_route_amp) else $error("amp moved under tracking");

  property p_len_match;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_r == DCD_DATA) |-> len_r == len_of(addr_r);
  endproperty
  a_len_match: assert property (p_len_match) else $error("frame length lost");

  sequence s_last_byte;
    (state_r == DCD_DATA) && take_w && (cnt_r + 4'h1 == len_of(addr_r));
  endsequence

  sequence s_exec_once;
    exec_w ##1 !exec_w;
  endsequence

  property p_last_byte;
    @(posedge sys_clk_i) disable iff (rst_i)
      s_last_byte |=> s_exec_once;
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("frame end missed");

  property p_restore_clears;
    @(posedge sys_clk_i) disable iff (rst_i)
      restore_default_pulse_o |=> !activity_lamp_o && !preamp_on_o && steps_o == '0 &&
        input_tuning_word_o == `DCD_RST_TUNE;
  endproperty
  a_restore_clears: assert property (p_restore_clears) else $error("defaults not restored");

  property p_preamp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_PREAMP) |=> preamp_on_o == $past(data_r[0]);
  endproperty
  a_preamp: assert property (p_preamp) else $error("amplifier mismatch");

  property p_step_in1;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_STEP && data_r[10:8] == `DCD_STEP_IN1) |=>
        steps_o.in1 == $past(data_r[7:0]);
  endproperty
  a_step_in1: assert property (p_step_in1) else $error("attenuator value mismatch");

  property p_step_ignore;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_STEP && data_r[10:8] == 3'h2) |=> $stable(steps_o);
  endproperty
  a_step_ignore: assert property (p_step_ignore) else $error("unused select moved steps");

  property p_auto_load;
    @(posedge sys_clk_i) disable iff (rst_i)
      (exec_w && addr_r == `DCD_ADDR_AUTO && data_r[1]) |=>
        auto_o.expected_output_level == $past(data_r[31:24]);
  endproperty
  a_auto_load: assert property (p_auto_load) else $error("level not loaded");
endmodule

/* File: dcd_host_model.sv */
// Host model that sends command frames byte by byte and reads acknowledge bytes.
`timescale 1ns/100ps
module dcd_host_model (
  input wire logic sys_clk_i,
  input wire logic rx_ready_i,
  input wire logic ack_valid_i,
  input wire logic [7:0] ack_byte_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic ack_ready_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    ack_ready_o = 1'b0;
  end

  // Sends a whole frame; an idle byte lane shows the inverse of the last byte.
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(negedge sys_clk_i);
      rx_valid_o = 1'b1;
      rx_byte_o = f[i];
      while (rx_ready_i !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
  endtask

  // Waits a bounded time for the acknowledge, then takes it after a chosen delay.
  task automatic take_ack(input int slow, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    while (ack_valid_i !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    ok = (ack_valid_i === 1'b1);
    b = 8'h00;
    if (ok) begin
      repeat (slow) @(negedge sys_clk_i);
      ack_ready_o = 1'b1;
      @(posedge sys_clk_i);
      b = ack_byte_i;
      @(negedge sys_clk_i);
      ack_ready_o = 1'b0;
    end
  endtask
endmodule

/* File: tb_downconverter_config_command_decoder.sv */
// Self-checking testbench for the command decoder.
`timescale 1ns/100ps
`include "dcd_params.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, a); end end
module tb_downconverter_config_command_decoder;
  import dcd_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ack_enable_i = 1'b1;
  logic rx_valid_i;
  logic ack_ready_i;
  logic [7:0] rx_byte_i;
  wire rx_ready_o;
  wire ack_valid_o;
  wire lamp;
  wire preamp;
  wire [7:0] ack_byte_o;
  wire [7:0] oth_a;
  wire [23:0] oth_d;
  wire [47:0] in_w;
  wire [47:0] dir_w;
  wire [47:0] out_w;
  wire [5:0] pul;
  dcd_steps_s steps;
  dcd_route_s route;
  dcd_auto_s auto;
  int errors = 0;
  int tests_run = 0;
  int pc[6];

  always #25 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (pul[i] === 1'b1) pc[i]++;
    end
  end

  dcd_decoder DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .rx_ready_o(rx_ready_o), .ack_enable_i(ack_enable_i), .ack_valid_o(ack_valid_o),
    .ack_byte_o(ack_byte_o), .ack_ready_i(ack_ready_i), .activity_lamp_o(lamp),
    .input_tuning_word_o(in_w), .input_tune_pulse_o(pul[0]),
    .first_oscillator_direct_o(dir_w), .first_oscillator_direct_pulse_o(pul[1]),
    .output_tuning_word_o(out_w), .output_tune_pulse_o(pul[2]), .preamp_on_o(preamp),
    .steps_o(steps), .route_o(route), .auto_o(auto), .reprogram_pulse_o(pul[3]),
    .restore_default_pulse_o(pul[4]), .other_addr_o(oth_a), .other_data_o(oth_d),
    .other_pulse_o(pul[5]));

  dcd_host_model HOST (
    .sys_clk_i(sys_clk_i), .rx_ready_i(rx_ready_o), .ack_valid_i(ack_valid_o),
    .ack_byte_i(ack_byte_o), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
    .ack_ready_o(ack_ready_i));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Writes one frame and, when acknowledges are on, reads and checks the acknowledge.
  task automatic wr(input logic [7:0] f[$]);
    logic [7:0] b;
    bit ok;
    HOST.send(f);
    if (ack_enable_i) begin
      `CHK("ready_while_ack", 1'b0, rx_ready_o)
      HOST.take_ack(f.size() % 3, b, ok);
      `CHK("ack_seen", 1'b1, ok)
      `CHK("ack_byte", `DCD_ACK_BYTE, b)
    end else begin
      repeat (3) @(negedge sys_clk_i);
    end
  endtask

  task automatic s_lamp();
    HOST.send('{8'h30});
    wr('{`DCD_ADDR_LAMP, 8'h01});
    `CHK("lamp_on", 1'b1, lamp)
    wr('{`DCD_ADDR_LAMP, 8'h00});
    `CHK("lamp_off", 1'b0, lamp)
  endtask

  task automatic s_tune();
    wr('{`DCD_ADDR_IN_TUNE, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00});
    `CHK("in_word", 48'h060504030201, in_w)
    `CHK("in_pulse", 1, pc[0])
    wr('{`DCD_ADDR_IN_TUNE, 8'haa, 8'hbb, 8'hcc, 8'hdd, 8'hee, 8'hff, 8'h01});
    `CHK("direct_word", 48'hffeeddccbbaa, dir_w)
    `CHK("in_kept", 48'h060504030201, in_w)
    `CHK("direct_pulse", 1, pc[1])
    wr('{`DCD_ADDR_OUT_TUNE, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00});
    `CHK("out_word", 48'h665544332211, out_w)
    `CHK("out_pulse", 1, pc[2])
  endtask

  task automatic s_steps();
    for (int i = 0; i < 5; i++) begin
      wr('{`DCD_ADDR_STEP, {i[3:0], 4'h5}, i[7:0], 8'h00});
    end
    `CHK("steps", 32'h05153545, steps)
  endtask

  task automatic s_gain();
    wr('{`DCD_ADDR_PREAMP, 8'h01});
    `CHK("preamp_on", 1'b1, preamp)
    wr('{`DCD_ADDR_PREAMP, 8'h00});
    `CHK("preamp_off", 1'b0, preamp)
    wr('{`DCD_ADDR_ROUTE, 8'h0f});
    `CHK("route_all", 4'hf, route)
    `CHK("route_amp", 1'b1, preamp)
    wr('{`DCD_ADDR_AUTO, 8'h17, 8'h85, 8'h14, 8'h9e, 8'h00});
    `CHK("auto_load", {4'b1110, 24'h85149e}, auto)
    wr('{`DCD_ADDR_ROUTE, 8'h00});
    `CHK("route_none", 4'h0, route)
    `CHK("amp_tracked", 1'b1, preamp)
    wr('{`DCD_ADDR_AUTO, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00});
    `CHK("auto_noload", {4'b0110, 24'h85149e}, auto)
    wr('{`DCD_ADDR_ROUTE, 8'h00});
    `CHK("amp_manual", 1'b0, preamp)
  endtask

  task automatic s_reload();
    wr('{`DCD_ADDR_RELOAD, 8'h00});
    `CHK("reprogram", 1, pc[3])
    wr('{`DCD_ADDR_LAMP, 8'h01});
    wr('{`DCD_ADDR_RELOAD, 8'h01});
    `CHK("restore", 1, pc[4])
    `CHK("lamp_default", 1'b0, lamp)
    `CHK("tune_default", 48'h0, in_w)
  endtask

  task automatic s_other();
    wr('{`DCD_ADDR_TRIM, 8'h34, 8'h12, 8'h00});
    `CHK("other_addr", `DCD_ADDR_TRIM, oth_a)
    `CHK("other_data", 24'h001234, oth_d)
    `CHK("other_pulse", 1, pc[5])
  endtask

  task automatic s_noack();
    @(negedge sys_clk_i);
    ack_enable_i = 1'b0;
    wr('{`DCD_ADDR_LAMP, 8'h01});
    `CHK("no_ack", 1'b0, ack_valid_o)
    `CHK("lamp_no_ack", 1'b1, lamp)
    ack_enable_i = 1'b1;
  endtask

  // A mid-run reset clears settings and leaves the decoder ready for a frame at once.
  task automatic s_reset();
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    `CHK("rst_lamp", 1'b0, lamp)
    `CHK("rst_ready", 1'b1, rx_ready_o)
    wr('{`DCD_ADDR_IN_TUNE, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h00});
    `CHK("rst_in_word", 48'h605040302010, in_w)
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors++;
    end_sim();
  end

  initial begin
    repeat (12) @(negedge sys_clk_i);
    rst_i = 1'b0;
    s_lamp();
    s_tune();
    s_steps();
    s_gain();
    s_reload();
    s_other();
    s_noack();
    s_reset();
    end_sim();
  end
endmodule
